/* File: ctm_checker.sv */
/* bus handshake and frozen-output checks for ctm_top.
 assumes: bound to ctm_top; one clock, async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module ctm_checker (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [15:0] MATCH_OUT,
	input wire logic IRQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	wire wtake = AWVALID && AWREADY && WVALID && WREADY;
	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
	rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read answer dropped");
	write_answer_a: assert property (wtake |-> ##2 BVALID) else $error("no write answer");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID) else $error("no read answer");
	write_block_a: assert property (BVALID |-> !AWREADY && !WREADY) else $error("write taken while answering");
	read_block_a: assert property (RVALID |-> !ARREADY) else $error("read taken while answering");
	strobe_error_a: assert property (wtake && WSTRB != 4'hf |-> ##2 BRESP == 2'h2) else $error("partial strobe accepted");
	unmapped_error_a: assert property (wtake && AWADDR[5:0] > 6'h38 |-> ##2 BRESP == 2'h2) else $error("unmapped write accepted");
	frozen_out_a: assert property (!CE |=> $stable(MATCH_OUT) && $stable(IRQ)) else $error("outputs moved while frozen");
endmodule
bind ctm_top ctm_checker u_ctm_checker (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
	.BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
	.MATCH_OUT(MATCH_OUT), .IRQ(IRQ));
`default_nettype wire

/* File: ctm_defs.vh */
/*
 constants for the match/capture counter/timer block: register offsets,
 field positions, bus response codes and action codes.
 assumes: included by bare name from the design files of this block.
*/
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// ----------------------------------------
// register map, byte offsets per timer slot
// ----------------------------------------
`define CTM_SLOT_BITS 6
`define CTM_OFS_CTRL 6'h00
`define CTM_OFS_COUNT 6'h04
`define CTM_OFS_PRESCALE 6'h08
`define CTM_OFS_PRECOUNT 6'h0c
`define CTM_OFS_MATCH0 6'h10
`define CTM_OFS_MATCH1 6'h14
`define CTM_OFS_MATCH2 6'h18
`define CTM_OFS_MATCH3 6'h1c
`define CTM_OFS_MCTRL 6'h20
`define CTM_OFS_OUTCTRL 6'h24
`define CTM_OFS_CAPCTRL 6'h28
`define CTM_OFS_CAP0 6'h2c
`define CTM_OFS_CAP1 6'h30
`define CTM_OFS_STATUS 6'h34
`define CTM_OFS_MASK 6'h38

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTM_CTRL_EN 0
`define CTM_CTRL_CLR 1
`define CTM_CTRL_CNTMODE 2
`define CTM_CTRL_CNTSRC 3
`define CTM_CTRL_EDGE_LO 4
`define CTM_CTRL_EDGE_HI 5
`define CTM_CTRL_CLRCAP 6
`define CTM_CTRL_CLREN 7
`define CTM_CTRL_CLREDGE 8

// ----------------------------------------
// match control: 3 bits per channel (irq, reset, stop)
// ----------------------------------------
`define CTM_MC_IRQ 0
`define CTM_MC_RST 1
`define CTM_MC_STOP 2
`define CTM_MC_W 3

// output action codes, 2 bits per channel
`define CTM_ACT_NONE 2'h0
`define CTM_ACT_LOW 2'h1
`define CTM_ACT_HIGH 2'h2
`define CTM_ACT_TOGGLE 2'h3

// capture control: 3 bits per channel (rise, fall, irq)
`define CTM_CC_RISE 0
`define CTM_CC_FALL 1
`define CTM_CC_IRQ 2
`define CTM_CC_W 3

// status bits: matches 0..3, captures 4..5
`define CTM_ST_CAP0 4
`define CTM_ST_W 6

`define CTM_NUM_MATCH 4
`define CTM_RESP_OKAY 2'h0
`define CTM_RESP_SLVERR 2'h2

`endif

/* File: ctm_pins.sv */
/* external pulse source on the capture pins.
 assumes: go is a one-cycle request; a pulse lasts len clock cycles. */
`timescale 1ns/100ps
`default_nettype none
module ctm_pins (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic go,
	input wire logic [2:0] sel,
	input wire logic [7:0] len,
	output logic [7:0] CAP_PIN,
	output logic busy
);
	logic [7:0] cnt;
	assign busy = cnt != 8'h0;
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			cnt <= 8'h0;
			CAP_PIN <= 8'h0;
		end else if (go) begin
			cnt <= len;
			CAP_PIN[sel] <= 1'b1;
		end else if (cnt == 8'h1) begin
			cnt <= 8'h0;
			CAP_PIN <= 8'h0;
		end else if (busy) begin
			cnt <= cnt - 8'h1;
		end
	end
endmodule
`default_nettype wire

/* File: ctm_sync.v */
/*
 two flip-flop synchroniser for a pin input.
 assumes: single clock domain, clock enable freezes the flops.
*/
`timescale 1ns/100ps
`default_nettype none
module ctm_sync (
	input wire CLOCK,
	input wire RST_B,
	input wire CE,
	input wire d,
	output reg q
);
	reg stage1;

	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			stage1 <= 1'b0;
			q <= 1'b0;
		end else if (CE) begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: ctm_timer.v */
/*
 one counter/timer: prescaler, count, four matches with actions and outputs,
 two capture channels with clear-on-capture, counter mode.
 assumes: register writes arrive as one-cycle strobes from the bus slave;
 capture inputs are already synchronised.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_timer #(
	parameter W = 32
) (
	input wire CLOCK,
	input wire RST_B,
	input wire CE,
	input wire wr,
	input wire [5:0] wr_ofs,
	input wire [31:0] wr_data,
	input wire [5:0] rd_ofs,
	output reg [31:0] rd_data,
	input wire [1:0] cap_in,
	output reg [3:0] mat_out,
	output wire irq
);
	reg [8:0] ctrl;
	reg [W-1:0] count;
	reg [W-1:0] prescale;
	reg [W-1:0] precount;
	reg [W-1:0] match [0:3];
	reg [11:0] mctrl;
	reg [7:0] outctrl;
	reg [5:0] capctrl;
	reg [W-1:0] cap [0:1];
	reg [`CTM_ST_W-1:0] status;
	reg [`CTM_ST_W-1:0] mask;
	reg [1:0] cap_prev;
	reg [3:0] mhit_prev;
	reg [3:0] next_mat;
	reg [`CTM_ST_W-1:0] events;
	reg tick;
	reg stop_hit;
	reg rst_hit;
	reg clr_evt;
	wire adv;
	wire [1:0] rise = cap_in & ~cap_prev;
	wire [1:0] fall = ~cap_in & cap_prev;
	wire cnt_in = ctrl[`CTM_CTRL_CNTSRC] ? cap_in[1] : cap_in[0];
	wire cnt_rise = ctrl[`CTM_CTRL_CNTSRC] ? rise[1] : rise[0];
	wire cnt_fall = ctrl[`CTM_CTRL_CNTSRC] ? fall[1] : fall[0];
	wire [1:0] cap_evt;
	wire [3:0] mhit;
	wire [3:0] mnew = mhit & ~mhit_prev;
	integer i;
	integer j;

	// ----------------------------------------
	// match compare and capture events
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gm
			assign mhit[g] = (count == match[g]);
		end
		for (g = 0; g < 2; g = g + 1) begin : gc
			assign cap_evt[g] = (capctrl[g*`CTM_CC_W+`CTM_CC_RISE] & rise[g]) |
				(capctrl[g*`CTM_CC_W+`CTM_CC_FALL] & fall[g]);
		end
	endgenerate

	assign irq = |(status & mask);

	always @* begin
		// counter mode: edges of selected capture input, else prescaled clock
		if (ctrl[`CTM_CTRL_CNTMODE])
			tick = (ctrl[`CTM_CTRL_EDGE_LO] & cnt_rise) | (ctrl[`CTM_CTRL_EDGE_HI] & cnt_fall);
		else
			tick = (precount == prescale);
		stop_hit = 1'b0;
		rst_hit = 1'b0;
		events = {`CTM_ST_W{1'b0}};
		next_mat = mat_out;
		for (i = 0; i < `CTM_NUM_MATCH; i = i + 1) begin
			if (mnew[i]) begin
				events[i] = mctrl[i*`CTM_MC_W+`CTM_MC_IRQ];
				stop_hit = stop_hit | mctrl[i*`CTM_MC_W+`CTM_MC_STOP];
				rst_hit = rst_hit | mctrl[i*`CTM_MC_W+`CTM_MC_RST];
				case (outctrl[i*2+:2])
					`CTM_ACT_LOW: next_mat[i] = 1'b0;
					`CTM_ACT_HIGH: next_mat[i] = 1'b1;
					`CTM_ACT_TOGGLE: next_mat[i] = ~mat_out[i];
					default: next_mat[i] = mat_out[i];
				endcase
			end
		end
		events[`CTM_ST_CAP0] = cap_evt[0] & capctrl[`CTM_CC_IRQ];
		events[`CTM_ST_CAP0+1] = cap_evt[1] & capctrl[`CTM_CC_W+`CTM_CC_IRQ];
		// clear on chosen edge of chosen capture input
		clr_evt = ctrl[`CTM_CTRL_CLREN] &
			(ctrl[`CTM_CTRL_CLRCAP] ? (ctrl[`CTM_CTRL_CLREDGE] ? fall[1] : rise[1]) :
			(ctrl[`CTM_CTRL_CLREDGE] ? fall[0] : rise[0]));
	end

	// count advances on a tick unless held, disabled or halted by a match
	assign adv = ctrl[`CTM_CTRL_EN] & ~ctrl[`CTM_CTRL_CLR] & tick & ~stop_hit;

	// ----------------------------------------
	// state
	// ----------------------------------------
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl <= 9'h000;
			count <= {W{1'b0}};
			prescale <= {W{1'b0}};
			precount <= {W{1'b0}};
			for (j = 0; j < 4; j = j + 1)
				match[j] <= {W{1'b0}};
			mctrl <= 12'h000;
			outctrl <= 8'h00;
			capctrl <= 6'h00;
			cap[0] <= {W{1'b0}};
			cap[1] <= {W{1'b0}};
			status <= {`CTM_ST_W{1'b0}};
			mask <= {`CTM_ST_W{1'b0}};
			cap_prev <= 2'h0;
			mhit_prev <= 4'h0;
			mat_out <= 4'h0;
		end else if (CE) begin
			cap_prev <= cap_in;
			mhit_prev <= mhit;
			mat_out <= next_mat;
			// capture holds the count reached this cycle, before any clear
			if (cap_evt[0])
				cap[0] <= count + {{(W-1){1'b0}}, adv};
			if (cap_evt[1])
				cap[1] <= count + {{(W-1){1'b0}}, adv};
			// set wins over write-one-to-clear
			if (wr && wr_ofs == `CTM_OFS_STATUS)
				status <= (status & ~wr_data[`CTM_ST_W-1:0]) | events;
			else
				status <= status | events;
			if (ctrl[`CTM_CTRL_EN] && !ctrl[`CTM_CTRL_CLR]) begin
				if (!ctrl[`CTM_CTRL_CNTMODE])
					precount <= tick ? {W{1'b0}} : precount + 1'b1;
				if (adv)
					count <= count + 1'b1;
			end
			if (rst_hit || ctrl[`CTM_CTRL_CLR] || clr_evt) begin
				count <= {W{1'b0}};
				precount <= {W{1'b0}};
			end
			if (stop_hit)
				ctrl[`CTM_CTRL_EN] <= 1'b0;
			if (wr) begin
				case (wr_ofs)
					`CTM_OFS_CTRL: ctrl <= wr_data[8:0];
					`CTM_OFS_COUNT: count <= wr_data[W-1:0];
					`CTM_OFS_PRESCALE: prescale <= wr_data[W-1:0];
					`CTM_OFS_PRECOUNT: precount <= wr_data[W-1:0];
					`CTM_OFS_MATCH0: match[0] <= wr_data[W-1:0];
					`CTM_OFS_MATCH1: match[1] <= wr_data[W-1:0];
					`CTM_OFS_MATCH2: match[2] <= wr_data[W-1:0];
					`CTM_OFS_MATCH3: match[3] <= wr_data[W-1:0];
					`CTM_OFS_MCTRL: mctrl <= wr_data[11:0];
					`CTM_OFS_OUTCTRL: outctrl <= wr_data[7:0];
					`CTM_OFS_CAPCTRL: capctrl <= wr_data[5:0];
					`CTM_OFS_MASK: mask <= wr_data[`CTM_ST_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		rd_data = 32'h0000_0000;
		case (rd_ofs)
			`CTM_OFS_CTRL: rd_data[8:0] = ctrl;
			`CTM_OFS_COUNT: rd_data[W-1:0] = count;
			`CTM_OFS_PRESCALE: rd_data[W-1:0] = prescale;
			`CTM_OFS_PRECOUNT: rd_data[W-1:0] = precount;
			`CTM_OFS_MATCH0: rd_data[W-1:0] = match[0];
			`CTM_OFS_MATCH1: rd_data[W-1:0] = match[1];
			`CTM_OFS_MATCH2: rd_data[W-1:0] = match[2];
			`CTM_OFS_MATCH3: rd_data[W-1:0] = match[3];
			`CTM_OFS_MCTRL: rd_data[11:0] = mctrl;
			`CTM_OFS_OUTCTRL: rd_data[7:0] = outctrl;
			`CTM_OFS_CAPCTRL: rd_data[5:0] = capctrl;
			`CTM_OFS_CAP0: rd_data[W-1:0] = cap[0];
			`CTM_OFS_CAP1: rd_data[W-1:0] = cap[1];
			`CTM_OFS_STATUS: rd_data[`CTM_ST_W-1:0] = status;
			`CTM_OFS_MASK: rd_data[`CTM_ST_W-1:0] = mask;
			default: rd_data = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

/* File: ctm_top.v */
/*
 four counter/timers (two 32-bit, two 16-bit) behind one AXI4-Lite slave.
 assumes: capture pins are asynchronous; one clock, clock enable freezes all.
*/
// Operation
// - two 32-bit and two 16-bit timers with identical behaviour.
// - timer mode advances count on prescaled system clock cycles.
// - prescaler as wide as count, programmable, divides counter clock.
// - four match values per timer; equality triggers configured actions.
// - match may let counting continue, interrupt only if enabled.
// - match may halt the counter, optional interrupt.
// - match may reset the counter to zero, optional interrupt.
// - four match outputs: go low, go high, toggle, or unchanged.
// - two capture channels copy count on input edge, optional interrupt.
// - chosen capture edge may clear counter and prescaler.
// - clear on one edge, capture on other, gives pulse width.
// - counter mode selectable besides timer mode.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_top (
	input wire CLOCK,
	input wire RST_B,
	input wire CE,
	input wire [7:0] AWADDR,
	input wire AWVALID,
	output wire AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output wire WREADY,
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	input wire [7:0] ARADDR,
	input wire ARVALID,
	output wire ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	input wire [7:0] CAP_PIN,
	output wire [15:0] MATCH_OUT,
	output wire IRQ
);
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	wire [7:0] cap_sync;
	wire [31:0] rd_word [0:3];
	wire [3:0] irqs;
	wire do_write = aw_held && w_held && !BVALID;
	wire [1:0] rsel = ARADDR[7:`CTM_SLOT_BITS];
	wire [1:0] wsel = aw_addr[7:`CTM_SLOT_BITS];
	reg wstrb_ok;
	wire wok = (aw_addr[5:0] <= `CTM_OFS_MASK) && (aw_addr[1:0] == 2'h0) && wstrb_ok;

	assign AWREADY = CE && !aw_held && !BVALID;
	assign WREADY = CE && !w_held && !BVALID;
	assign ARREADY = CE && !RVALID;
	assign IRQ = |irqs;

	// ----------------------------------------
	// pin synchronisers and timers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gs
			ctm_sync u_sync (
				.CLOCK(CLOCK),
				.RST_B(RST_B),
				.CE(CE),
				.d(CAP_PIN[g]),
				.q(cap_sync[g])
			);
		end
		for (g = 0; g < 4; g = g + 1) begin : gt
			ctm_timer #(.W(g < 2 ? 32 : 16)) u_tmr (
				.CLOCK(CLOCK),
				.RST_B(RST_B),
				.CE(CE),
				.wr(do_write && wok && wsel == g),
				.wr_ofs(aw_addr[5:0]),
				.wr_data(w_data),
				.rd_ofs(ARADDR[5:0]),
				.rd_data(rd_word[g]),
				.cap_in(cap_sync[g*2+:2]),
				.mat_out(MATCH_OUT[g*4+:4]),
				.irq(irqs[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			wstrb_ok <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `CTM_RESP_OKAY;
			RVALID <= 1'b0;
			RRESP <= `CTM_RESP_OKAY;
			RDATA <= 32'h0000_0000;
		end else if (CE) begin
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				wstrb_ok <= &WSTRB;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wok ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				if (ARADDR[5:0] <= `CTM_OFS_MASK && ARADDR[1:0] == 2'h0) begin
					RDATA <= rd_word[rsel];
					RRESP <= `CTM_RESP_OKAY;
				end else begin
					RDATA <= 32'h0000_0000;
					RRESP <= `CTM_RESP_SLVERR;
				end
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: ctm_top_test.sv */
/* self-checking bench of ctm_top over AXI4-Lite with a pulse source.
 assumes: ctm_defs.vh offsets; answer waits cut by the cycle limit. */
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_top_test;
	logic CLOCK, RST_B, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic [7:0] AWADDR, ARADDR, CAP_PIN;
	logic [31:0] WDATA, RDATA, rnd, v;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, r;
	logic [15:0] MATCH_OUT;
	logic go, busy;
	logic [2:0] sel;
	logic [7:0] len;
	int failures, check_count, cyc, i, t, p, m;
	ctm_top u_ctm_top (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .CAP_PIN(CAP_PIN), .MATCH_OUT(MATCH_OUT), .IRQ(IRQ));
	ctm_pins u_ctm_pins (.CLOCK(CLOCK), .RST_B(RST_B), .go(go), .sel(sel), .len(len), .CAP_PIN(CAP_PIN), .busy(busy));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] rs);
		logic pa, pw;
		@(posedge CLOCK);
		AWADDR <= a; WDATA <= d; WSTRB <= s; AWVALID <= 1; WVALID <= 1;
		pa = 1; pw = 1;
		while (pa | pw) begin
			@(posedge CLOCK);
			if (pa && AWREADY === 1'b1) begin
				AWVALID <= 0;
				pa = 0;
			end
			if (pw && WREADY === 1'b1) begin
				WVALID <= 0;
				pw = 0;
			end
		end
		// late bready lets the answer stand unaccepted for a while
		repeat (2) @(posedge CLOCK);
		BREADY <= 1;
		do @(posedge CLOCK); while (BVALID !== 1'b1);
		rs = BRESP;
		BREADY <= 0;
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] rs);
		@(posedge CLOCK);
		ARADDR <= a; ARVALID <= 1;
		do @(posedge CLOCK); while (ARREADY !== 1'b1);
		ARVALID <= 0;
		@(posedge CLOCK);
		RREADY <= 1;
		do @(posedge CLOCK); while (RVALID !== 1'b1);
		d = RDATA; rs = RRESP;
		RREADY <= 0;
	endtask
	task wreg(input [1:0] tm, input [5:0] o, input [31:0] d);
		wr({tm, o}, d, 4'hf, r);
		chk("bresp", {30'h0, r}, 32'h0);
	endtask
	task rreg(input [1:0] tm, input [5:0] o, input [31:0] msk, input [31:0] e);
		rd({tm, o}, v, r);
		chk("rresp", {30'h0, r}, 32'h0);
		chk("rdata", v & msk, e);
	endtask
	task pulse(input [2:0] s, input [7:0] l);
		@(posedge CLOCK);
		go <= 1; sel <= s; len <= l;
		@(posedge CLOCK);
		go <= 0;
		do @(negedge CLOCK); while (busy);
	endtask
	initial begin
		CLOCK = 0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		RST_B = 0; CE = 1; AWADDR = 0; AWVALID = 0; WDATA = 0; WSTRB = 0; WVALID = 0; BREADY = 0;
		ARADDR = 0; ARVALID = 0; RREADY = 0; go = 0; sel = 0; len = 0; rnd = 32'h585e;
		repeat (16) @(posedge CLOCK);
		RST_B <= 1;
		@(posedge CLOCK) CE <= 0;
		repeat (4) @(posedge CLOCK);
		CE <= 1;
		for (t = 0; t < 4; t++) begin
			rreg(t, `CTM_OFS_CTRL, 32'hffffffff, 0);
			rreg(t, `CTM_OFS_COUNT, 32'hffffffff, 0);
		end
		chk("match_out", {16'h0, MATCH_OUT}, 0);
		wr(8'h3c, 1, 4'hf, r);
		chk("unmapped", {30'h0, r}, 2);
		wr(8'h00, 1, 4'h3, r);
		chk("strobe", {30'h0, r}, 2);
		rd(8'h3c, v, r);
		chk("rd_unmapped", {30'h0, r}, 2);
		chk("rd_zero", v, 0);
		rreg(0, `CTM_OFS_CTRL, 32'hffffffff, 0);
		wreg(0, `CTM_OFS_MATCH1, 32'hffffffff);
		rreg(0, `CTM_OFS_MATCH1, 32'hffffffff, 32'hffffffff);
		wreg(2, `CTM_OFS_PRESCALE, 32'hffffffff);
		rreg(2, `CTM_OFS_PRESCALE, 32'hffffffff, 32'hffff);
		// ----
		// prescaled count, stop on match, interrupt
		// ----
		rnd = lfsr(rnd);
		p = rnd[1:0];
		m = 10 + rnd[6:2];
		wreg(0, `CTM_OFS_PRESCALE, p);
		wreg(0, `CTM_OFS_MATCH0, m);
		wreg(0, `CTM_OFS_MCTRL, 5);
		wreg(0, `CTM_OFS_MASK, 1);
		wreg(0, `CTM_OFS_CTRL, 1);
		for (i = 0; i < 400 && IRQ !== 1'b1; i++) @(negedge CLOCK);
		chk("irq", IRQ, 1);
		chk("ticks", (i >= (p + 1) * (m - 1) && i <= (p + 1) * m + 4), 1);
		rreg(0, `CTM_OFS_COUNT, 32'hffffffff, m);
		rreg(0, `CTM_OFS_CTRL, 32'h1, 0);
		rreg(0, `CTM_OFS_STATUS, 32'h1, 1);
		wreg(0, `CTM_OFS_STATUS, 1);
		chk("irq", IRQ, 0);
		wreg(0, `CTM_OFS_MCTRL, 2);
		wreg(0, `CTM_OFS_CTRL, 3);
		wreg(0, `CTM_OFS_CTRL, 1);
		repeat (3 * (p + 1) * m) @(posedge CLOCK);
		rd({2'd0, `CTM_OFS_COUNT}, v, r);
		chk("wrap", (v <= m), 1);
		// ----
		// output actions
		// ----
		wreg(2, `CTM_OFS_PRESCALE, 0);
		for (i = 0; i < 4; i++) wreg(2, `CTM_OFS_MATCH0 + {i[3:0], 2'b00}, 5);
		wreg(2, `CTM_OFS_MCTRL, 4);
		wreg(2, `CTM_OFS_OUTCTRL, 8'h39);
		wreg(2, `CTM_OFS_CTRL, 1);
		repeat (20) @(posedge CLOCK);
		chk("outputs", MATCH_OUT[11:8], 4'b0110);
		// ----
		// pulse width by clear and capture
		// ----
		rnd = lfsr(rnd);
		wreg(1, `CTM_OFS_CAPCTRL, 6);
		wreg(1, `CTM_OFS_MASK, 32'h10);
		wreg(1, `CTM_OFS_CTRL, 32'h81);
		pulse(2, 4 + rnd[5:0]);
		repeat (6) @(posedge CLOCK);
		rreg(1, `CTM_OFS_CAP0, 32'hffffffff, 4 + rnd[5:0]);
		rreg(1, `CTM_OFS_STATUS, 32'h30, 32'h10);
		chk("irq", IRQ, 1);
		wreg(1, `CTM_OFS_MASK, 0);
		chk("irq", IRQ, 0);
		wreg(1, `CTM_OFS_MASK, 32'h10);
		wreg(1, `CTM_OFS_STATUS, 32'h3f);
		chk("irq", IRQ, 0);
		// ----
		// counter mode on capture edges
		// ----
		rnd = lfsr(rnd);
		wreg(3, `CTM_OFS_MATCH0, 2);
		wreg(3, `CTM_OFS_MCTRL, 1);
		wreg(3, `CTM_OFS_CTRL, 32'h15);
		for (i = 0; i < 3 + rnd[1:0]; i++) pulse(6, 2);
		repeat (6) @(posedge CLOCK);
		rreg(3, `CTM_OFS_COUNT, 32'hffffffff, 3 + rnd[1:0]);
		rreg(3, `CTM_OFS_STATUS, 32'h1, 1);
		// falling edges of the second capture input
		wreg(3, `CTM_OFS_CTRL, 32'h2d);
		wreg(3, `CTM_OFS_COUNT, 0);
		pulse(7, 2);
		pulse(7, 2);
		repeat (6) @(posedge CLOCK);
		rreg(3, `CTM_OFS_COUNT, 32'hffffffff, 2);
		report_and_stop;
	end
endmodule
`default_nettype wire
